// ### design/serial_ctrl_pkg.sv
// Purpose: Shared constants and carriers for the serial control-two slice
// Assumes: APB with 32-bit data, one word per register
// Notes:   Bit positions of the control word match the hardware layout
package serial_ctrl_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] OFS_CONTROL_TWO = 8'h00;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h08;
  localparam logic [7:0] OFS_LINE_STATUS = 8'h0C;
  localparam logic [7:0] OFS_CONTROL_EXT = 8'h10;

  // ----------------------------------------
  // Control-two field positions
  // ----------------------------------------
  localparam int BIT_TX_EMPTY_IRQ_EN = 7;
  localparam int BIT_TX_DONE_IRQ_EN  = 6;
  localparam int BIT_RX_IRQ_EN       = 5;
  localparam int BIT_IDLE_IRQ_EN     = 4;
  localparam int BIT_SENDER_ON       = 3;
  localparam int BIT_RX_ON           = 2;
  localparam int BIT_RX_MUTE         = 1;
  localparam int BIT_SEND_BREAK      = 0;

  localparam logic [7:0] CONTROL_TWO_RESET = 8'h00;
  localparam logic [4:0] IRQ_MASK_RESET    = 5'h00;

  // Event-status bits: 0 tx empty, 1 tx done, 2 rx full, 3 overrun, 4 idle
  localparam int NUM_EVENTS = 5;

  // Bit time in CPU clocks (one bit = 16 sampling ticks by default)
  localparam logic [15:0] BIT_TIME_CYCLES_DEFAULT = 16'h0010;

  typedef enum logic [1:0] {TX_OFF, TX_DELAY, TX_RUN, TX_PREAMBLE} tx_state_e;

  typedef struct packed {
    logic tx_buf_empty_flag;
    logic tx_done_flag;
    logic rx_full_flag;
    logic overrun_flag;
    logic idle_flag;
  } status_flags_s;

endpackage

// ### design/serial_ctrl_two.sv
// Purpose: Control-two register slice of an async serial unit with APB access
// Assumes: Status flags come from the unit's data path, synchronous to ref_clk
// Notes:   All outputs registered; one shared interrupt line
//          Sticky events: a set beats a same-cycle clear
//          Direct sources are live; sticky ones pass the mask
//          A mute wake clears bit 1 without a software write
//          Bit-time delay is counted in ref_clk cycles
//          Unmapped offsets answer with an error, change nothing
//
// Summary of operation
// - tx empty enable gates tx empty flag
// - tx done enable gates completion flag
// - rx enable gates full or overrun
// - idle enable gates idle-line flag
// - sender_on enables the transmitter
// - sender_on toggle sends idle preamble after word
// - one bit time delay after sender_on set
// - pin released when both disabled or sender never set
// - eight control bits set by software, reset zero; a mute wake also clears bit 1
// - mute blocks reception flags and interrupts
// - mute wakes on idle or address mark
`timescale 1ns/1ps
module serial_ctrl_two
  import serial_ctrl_pkg::*;
#(
  parameter logic [15:0] BIT_TIME_CYCLES = BIT_TIME_CYCLES_DEFAULT
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Status from the data path
  input  wire status_flags_s flags_in,
  input  wire logic          tx_word_busy,
  input  wire logic          address_mark_seen,
  // Controls to the data path
  output logic               tx_enable,
  output logic               tx_start_ok,
  output logic               tx_send_preamble,
  output logic               tx_break,
  output logic               tx_pin_serial,
  output logic               rx_enable,
  output logic               rx_asleep,
  // Interrupt
  output logic               irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]            ctl;
    logic                  wake_on_mark;
    logic                  sender_ever;
    logic [NUM_EVENTS-1:0] evt_status;
    logic [NUM_EVENTS-1:0] evt_mask;
    logic [NUM_EVENTS-1:0] evt_prev;
    tx_state_e             tx_state;
    logic [15:0]           bit_cnt;
    logic                  preamble_due;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  tx_pin_serial;
    logic                  tx_start_ok;
    logic                  tx_send_preamble;
    logic                  irq;
  } state_s;

  state_s st;
  state_s next_st;

  logic                  wr_acc;
  logic                  rd_acc;
  logic                  mapped;
  logic [NUM_EVENTS-1:0] flag_vec;
  logic [NUM_EVENTS-1:0] gated_flags;
  logic [NUM_EVENTS-1:0] evt_rise;
  logic [NUM_EVENTS-1:0] evt_w1c;
  logic                  src_tx_empty;
  logic                  src_tx_done;
  logic                  src_rx;
  logic                  src_idle;
  logic                  access_open;
  logic                  sel_ctl;
  logic                  sel_status;
  logic                  sel_mask;
  logic                  sel_line;
  logic                  sel_ext;
  logic                  ctl_write;
  logic                  mute_now;
  logic                  wake_hit;
  logic                  tx_cnt_done;
  logic                  irq_direct;
  logic                  irq_sticky;
  logic [31:0]           line_word;
  logic [31:0]           rd_word;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign access_open = psel && penable && !st.pready;
  assign wr_acc      = access_open && pwrite;
  assign rd_acc      = access_open && !pwrite;
  assign sel_ctl     = (paddr == OFS_CONTROL_TWO);
  assign sel_status  = (paddr == OFS_IRQ_STATUS);
  assign sel_mask    = (paddr == OFS_IRQ_MASK);
  assign sel_line    = (paddr == OFS_LINE_STATUS);
  assign sel_ext     = (paddr == OFS_CONTROL_EXT);
  assign ctl_write   = wr_acc && sel_ctl;
  // Anything else is refused with pslverr
  assign mapped      = sel_ctl || sel_status || sel_mask || sel_line || sel_ext;

  // ----------------------------------------
  // Receive gating
  // ----------------------------------------
  assign mute_now    = st.ctl[BIT_RX_MUTE];
  assign wake_hit    = (!st.wake_on_mark && flags_in.idle_flag) || (st.wake_on_mark && address_mark_seen);
  // Last cycle of the one bit-time start delay
  assign tx_cnt_done = (st.bit_cnt <= 16'h0001);

  // While muted, reception flags are held off
  assign flag_vec = {flags_in.idle_flag && !st.ctl[BIT_RX_MUTE],
                     flags_in.overrun_flag && !st.ctl[BIT_RX_MUTE],
                     flags_in.rx_full_flag && !st.ctl[BIT_RX_MUTE],
                     flags_in.tx_done_flag,
                     flags_in.tx_buf_empty_flag};

  // ----------------------------------------
  // Interrupt sources
  // ----------------------------------------
  assign src_tx_empty = st.ctl[BIT_TX_EMPTY_IRQ_EN] && flags_in.tx_buf_empty_flag;
  assign src_tx_done  = st.ctl[BIT_TX_DONE_IRQ_EN] && flags_in.tx_done_flag;
  assign src_rx       = st.ctl[BIT_RX_IRQ_EN] && (flag_vec[2] || flag_vec[3]);
  assign src_idle     = st.ctl[BIT_IDLE_IRQ_EN] && flag_vec[4];
  // Direct sources ignore the mask register
  assign irq_direct   = src_tx_empty || src_tx_done || src_rx || src_idle;
  // Sticky lanes let a short flag pulse still reach software
  assign irq_sticky   = |(st.evt_status & st.evt_mask);

  // ----------------------------------------
  // Event status
  // ----------------------------------------
  // Sticky event capture, one lane per event; set beats a same-cycle clear
  // Limitation: write-one-clear bits above the event lanes are ignored
  genvar g;
  generate
    for (g = 0; g < NUM_EVENTS; g++) begin : g_evt
      assign gated_flags[g] = flag_vec[g];
      assign evt_rise[g]    = gated_flags[g] && !st.evt_prev[g];
      assign evt_w1c[g]     = wr_acc && (paddr == OFS_IRQ_STATUS) && pwdata[g];
    end
  endgenerate

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  assign line_word = {26'h0000000, st.sender_ever, st.tx_state, flag_vec[4:3], st.ctl[BIT_RX_MUTE]};

  always_comb begin
    rd_word = 32'h00000000;
    case (paddr)
      OFS_CONTROL_TWO: rd_word = {24'h000000, st.ctl};
      OFS_IRQ_STATUS:  rd_word = {27'h0000000, st.evt_status};
      OFS_IRQ_MASK:    rd_word = {27'h0000000, st.evt_mask};
      OFS_LINE_STATUS: rd_word = line_word;
      OFS_CONTROL_EXT: rd_word = {31'h00000000, st.wake_on_mark};
      default:         rd_word = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_st = st;

    // ----------------------------------------
    // APB handshake
    // ----------------------------------------
    next_st.pready  = access_open;
    next_st.pslverr = access_open && !mapped;
    next_st.evt_prev = gated_flags;
    next_st.evt_status = (st.evt_status & ~evt_w1c) | evt_rise;


    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    // Software writes change the control bits; a mute wake may also clear bit 1
    if (wr_acc) begin
      case (paddr)
        OFS_CONTROL_TWO: next_st.ctl = pwdata[7:0];
        OFS_IRQ_MASK:    next_st.evt_mask = pwdata[NUM_EVENTS-1:0];
        OFS_CONTROL_EXT: next_st.wake_on_mark = pwdata[0];
        default:         next_st.ctl = st.ctl;
      endcase
    end

    // ----------------------------------------
    // Mute wake
    // ----------------------------------------
    // A software write in the same cycle takes precedence over the wake
    // Wake from mute by idle line or address mark
    if (mute_now && !ctl_write) begin
      if (wake_hit) begin
        next_st.ctl[BIT_RX_MUTE] = 1'b0;
      end
    end


    // ----------------------------------------
    // Read data capture
    // ----------------------------------------
    if (rd_acc) begin
      next_st.prdata = rd_word;
    end else begin
      next_st.prdata = 32'h00000000;
    end

    // ----------------------------------------
    // Sender history
    // ----------------------------------------
    // Taken from the new word so the pin is serial on the enabling edge
    if (next_st.ctl[BIT_SENDER_ON]) begin
      next_st.sender_ever = 1'b1;
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------

    // Transmitter sequencing
    next_st.tx_start_ok      = 1'b0;
    next_st.tx_send_preamble = 1'b0;
    case (st.tx_state)
      // Idle until sender_on is seen
      TX_OFF: begin
        if (st.ctl[BIT_SENDER_ON]) begin
          next_st.tx_state = TX_DELAY;
          next_st.bit_cnt  = BIT_TIME_CYCLES;
        end
      end
      TX_DELAY: begin
        if (!st.ctl[BIT_SENDER_ON]) begin
          next_st.tx_state = TX_OFF;
        end else if (tx_cnt_done) begin
          next_st.tx_state = st.preamble_due ? TX_PREAMBLE : TX_RUN;
        end else begin
          next_st.bit_cnt = st.bit_cnt - 16'h0001;
        end
      end

      // Words may leave
      TX_RUN: begin
        next_st.tx_start_ok = 1'b1;
        if (!st.ctl[BIT_SENDER_ON]) begin
          // Clear during a word: the word still finishes, then a preamble
          next_st.preamble_due = tx_word_busy;
          next_st.tx_state     = TX_OFF;
          next_st.tx_start_ok  = 1'b0;
        end
      end

      // Preamble waits for the unfinished word
      TX_PREAMBLE: begin
        if (!tx_word_busy) begin
          next_st.tx_send_preamble = 1'b1;
          next_st.preamble_due     = 1'b0;
          next_st.tx_state         = TX_RUN;
        end
      end
      default: next_st.tx_state = TX_OFF;
    endcase


    // ----------------------------------------
    // Pin and interrupt
    // ----------------------------------------
    // Pin stays serial unless both disabled or sender never set
    next_st.tx_pin_serial = next_st.sender_ever && (next_st.ctl[BIT_SENDER_ON] || next_st.ctl[BIT_RX_ON]);

    next_st.irq = irq_direct || irq_sticky;
  end

  // ----------------------------------------
  // Register update
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{ctl:      CONTROL_TWO_RESET,
              evt_mask: IRQ_MASK_RESET,
              tx_state: TX_OFF,
              default:  '0};
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // APB
  assign prdata           = st.prdata;
  assign pready           = st.pready;
  assign pslverr          = st.pslverr;

  // Transmitter
  assign tx_enable        = st.ctl[BIT_SENDER_ON];
  assign tx_start_ok      = st.tx_start_ok;
  assign tx_send_preamble = st.tx_send_preamble;
  assign tx_break         = st.ctl[BIT_SEND_BREAK];
  assign tx_pin_serial    = st.tx_pin_serial;

  // Receiver
  assign rx_enable        = st.ctl[BIT_RX_ON];
  assign rx_asleep        = st.ctl[BIT_RX_MUTE];

  // Interrupt
  assign irq              = st.irq;

endmodule

// ### verif/serial_ctrl_two_monitor.sv
// Purpose: Port checker for serial_ctrl_two
// Assumes: Control word mirrored from APB writes
// Notes:   Bit 1 read back checked against rx_asleep, a wake may clear it
`timescale 1ns/1ps
module serial_ctrl_two_monitor
  import serial_ctrl_pkg::*;
#(
  parameter logic [15:0] BIT_TIME_CYCLES = BIT_TIME_CYCLES_DEFAULT
) (
  // Clock, reset, APB
  input wire logic          ref_clk,
  input wire logic          reset_n,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  // Unit side
  input wire status_flags_s flags_in,
  input wire logic          tx_enable,
  input wire logic          tx_start_ok,
  input wire logic          tx_pin_serial,
  input wire logic          rx_enable,
  input wire logic          rx_asleep,
  input wire logic          irq
);
  // Room for a preamble that waits on a word still in flight
  localparam int DLY_MAX = BIT_TIME_CYCLES + 40;
  logic [7:0] ctl;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl <= 8'h00;
    end else if (psel && penable && !pready && pwrite && paddr == OFS_CONTROL_TWO) begin
      ctl <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_tx_empty_irq: assert property (ctl[7] && flags_in.tx_buf_empty_flag |=> irq)
    else $error("irq missing for tx empty");
  a_tx_done_irq: assert property (ctl[6] && flags_in.tx_done_flag |=> irq)
    else $error("irq missing for tx done");
  a_rx_src_irq: assert property (ctl[5] && !rx_asleep && (flags_in.rx_full_flag || flags_in.overrun_flag) |=> irq)
    else $error("irq missing for receive");
  a_idle_irq: assert property (ctl[4] && !rx_asleep && flags_in.idle_flag |=> irq)
    else $error("irq missing for idle");
  a_enables_follow: assert property (tx_enable == ctl[3] && rx_enable == ctl[2])
    else $error("enable outputs differ from control word");
  a_start_delay: assert property ($rose(tx_enable) |-> (!tx_start_ok)[*4] ##[1:DLY_MAX] tx_start_ok)
    else $error("start delay wrong");
  a_pin_held: assert property (tx_enable |-> tx_pin_serial)
    else $error("pin released while sending enabled");
  a_read_back: assert property (pready && !pwrite && paddr == OFS_CONTROL_TWO |->
    prdata == {24'h000000, ctl[7:2], rx_asleep, ctl[0]}) else $error("control read mismatch");
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("no answer on access");
  cover property ($rose(irq));
  cover property ($rose(tx_start_ok));
  cover property (rx_asleep && flags_in.rx_full_flag);
endmodule
bind serial_ctrl_two serial_ctrl_two_monitor #(.BIT_TIME_CYCLES(BIT_TIME_CYCLES)) u_mon (
  .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .flags_in(flags_in),
  .tx_enable(tx_enable), .tx_start_ok(tx_start_ok), .tx_pin_serial(tx_pin_serial),
  .rx_enable(rx_enable), .rx_asleep(rx_asleep), .irq(irq));

// ### verif/serial_path_model.sv
// Purpose: Behavioural data path facing the control slice
// Assumes: Flags registered once, like a real data path
// Notes:   A word is a fixed cycle count, not a real frame
`timescale 1ns/1ps
module serial_path_model
  import serial_ctrl_pkg::*;
#(
  parameter int WORD_CYCLES = 20
) (
  // Clock and reset
  input wire logic          ref_clk,
  input wire logic          reset_n,
  // Bench side
  input wire status_flags_s flags_req,
  input wire logic          word_go,
  // Slice side
  input wire logic          tx_start_ok,
  output status_flags_s     flags_in,
  output logic              tx_word_busy,
  output logic              address_mark_seen
);
  int left;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_in <= '0;
      left <= 0;
    end else begin
      flags_in <= flags_req;
      // No word leaves before the slice allows it
      left <= (word_go && tx_start_ok) ? WORD_CYCLES : (left > 0 ? left - 1 : 0);
    end
  end
  assign tx_word_busy = (left > 0);
  assign address_mark_seen = 1'b0;
endmodule

// ### verif/test_serial_ctrl_two.sv
// Purpose: Self-checking bench for serial_ctrl_two
// Assumes: Flags reach the slice through the path model
// Notes:   Bit time cut to 4 clocks to keep the run short
`timescale 1ns/1ps
module test_serial_ctrl_two
  import serial_ctrl_pkg::*;
;
  logic          ref_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic          word_go = 1'b0, pready, pslverr, irq, tx_enable, tx_start_ok, tx_send_preamble;
  logic          tx_break, tx_pin_serial, rx_enable, rx_asleep, tx_word_busy, address_mark_seen, e;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0, prdata, q;
  status_flags_s flags_req = '0, flags_in;
  int            errors = 0, compares = 0, n;
  logic [13:0]   rows [8] = '{{8'h80, 5'h10, 1'b1}, {8'h00, 5'h10, 1'b0}, {8'h40, 5'h08, 1'b1},
    {8'h20, 5'h04, 1'b1}, {8'h20, 5'h02, 1'b1}, {8'h10, 5'h01, 1'b1}, {8'h10, 5'h1E, 1'b0}, {8'h22, 5'h04, 1'b0}};
  always #4 ref_clk = ~ref_clk;
  serial_ctrl_two #(.BIT_TIME_CYCLES(16'h0004)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flags_in(flags_in), .tx_word_busy(tx_word_busy), .address_mark_seen(address_mark_seen),
    .tx_enable(tx_enable), .tx_start_ok(tx_start_ok), .tx_send_preamble(tx_send_preamble), .tx_break(tx_break),
    .tx_pin_serial(tx_pin_serial), .rx_enable(rx_enable), .rx_asleep(rx_asleep), .irq(irq));
  serial_path_model u_path (.ref_clk(ref_clk), .reset_n(reset_n), .flags_req(flags_req), .word_go(word_go),
    .tx_start_ok(tx_start_ok), .flags_in(flags_in), .tx_word_busy(tx_word_busy),
    .address_mark_seen(address_mark_seen));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic final_report();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    apb(1'b0, OFS_CONTROL_TWO, 32'h0);
    chk("reset control", 32'h0, q);
    $display("test reset done");
    foreach (rows[i]) begin
      flags_req <= rows[i][5:1];
      apb(1'b1, OFS_CONTROL_TWO, {24'h0, rows[i][13:6]});
      repeat (3) @(posedge ref_clk);
      chk("irq", rows[i][0], irq);
      apb(1'b0, OFS_CONTROL_TWO, 32'h0);
      chk("control", rows[i][13:6], q);
    end
    flags_req <= '0;
    apb(1'b1, 8'h14, 32'hFF);
    chk("error flag", 1, e);
    $display("test table done");
    apb(1'b1, OFS_IRQ_MASK, 32'h01);
    flags_req <= 5'h10;
    repeat (3) @(posedge ref_clk);
    flags_req <= '0;
    repeat (3) @(posedge ref_clk);
    chk("sticky irq", 1, irq);
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk("masked irq", 0, irq);
    apb(1'b1, OFS_IRQ_STATUS, 32'h01);
    apb(1'b1, OFS_IRQ_MASK, 32'h01);
    repeat (2) @(posedge ref_clk);
    chk("cleared irq", 0, irq);
    $display("test interrupt done");
    apb(1'b1, OFS_CONTROL_TWO, 32'h08);
    n = 0;
    while (tx_start_ok !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    chk("start wait", 1, n >= 3 && n < 50);
    word_go <= 1'b1;
    @(posedge ref_clk);
    word_go <= 1'b0;
    apb(1'b1, OFS_CONTROL_TWO, 32'h0);
    apb(1'b1, OFS_CONTROL_TWO, 32'h08);
    n = 0;
    while (tx_send_preamble !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    chk("preamble", 1, tx_send_preamble);
    chk("word finished", 0, tx_word_busy);
    apb(1'b1, OFS_CONTROL_TWO, 32'h04);
    chk("pin kept", 1, tx_pin_serial);
    apb(1'b1, OFS_CONTROL_TWO, 32'h01);
    repeat (2) @(posedge ref_clk);
    chk("pin released", 0, tx_pin_serial);
    chk("break", 1, tx_break);
    apb(1'b1, OFS_CONTROL_TWO, 32'h02);
    chk("muted", 1, rx_asleep);
    flags_req <= 5'h01;
    repeat (3) @(posedge ref_clk);
    chk("woken", 0, rx_asleep);
    flags_req <= '0;
    $display("test transmitter done");
    final_report();
  end
endmodule
